// File: shared/wdg_pkg.sv
// constants shared by the guarded watchdog and its counter
// assumes a single system clock; the slow oscillator arrives as an enable level
`default_nettype none
package wdg_pkg;
  localparam logic [7:0] WDG_CLEAR_CODE = 8'hac;
  localparam logic [7:0] WDG_CLEAR_READ = 8'h9a;
  // bits 7..5 of the mode byte that software is expected to write
  localparam logic [2:0] WDG_MODE_TOP = 3'h3;
  localparam int WDG_CS_HI_BIT = 4;
  localparam int WDG_CS_LO_BIT = 3;
  localparam int WDG_CS_RATE_LSB = 0;
  localparam logic [7:0] WDG_MODE_RESET = 8'h67;
  localparam int WDG_CNT_WIDTH = 20;
  // self-programming caution: a block erase takes at least this long
  localparam int WDG_ERASE_MIN_US = 10000;
  localparam int WDG_CLK_MHZ = 40;
  localparam int WDG_ERASE_MIN_CYC = WDG_ERASE_MIN_US * WDG_CLK_MHZ;
endpackage
`default_nettype wire

// File: shared/wdg_cnt_if.sv
// carrier between the watchdog guard and its counter
// assumes both ends sit on CLK_I
`timescale 1ns/1ps
`default_nettype none
interface wdg_cnt_if;
  logic clear;
  logic run;
  logic [2:0] rate;
  logic overflow;
  modport guard (output clear, output run, output rate, input overflow);
  modport counter (input clear, input run, input rate, output overflow);
endinterface
`default_nettype wire

// File: rtl/wdg_counter.sv
// watchdog counter: counts ticks, flags overflow at the selected length
// assumes tick is a one-cycle enable from the clock source
`timescale 1ns/1ps
`default_nettype none
module wdg_counter
  import wdg_pkg::*;
#(
  parameter int CNT_WIDTH = WDG_CNT_WIDTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  wdg_cnt_if.counter cnt
);
  typedef struct packed {
    logic [CNT_WIDTH-1:0] count;
    logic overflow;
  } wdg_cnt_state_t;

  wdg_cnt_state_t state;
  wdg_cnt_state_t next_state;
  logic [CNT_WIDTH-1:0] limit;

  // rate 0 is the shortest period; each step doubles it
  assign limit = {CNT_WIDTH{1'b1}} >> (3'h7 - cnt.rate);
  assign cnt.overflow = state.overflow;

  always_comb begin
    next_state = state;
    next_state.overflow = 1'b0;
    if (cnt.clear) begin
      next_state.count = '0;
    end else if (cnt.run && tick_i) begin
      if (state.count >= limit) begin
        next_state.overflow = 1'b1;
        next_state.count = '0;
      end else begin
        next_state.count = state.count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // checks
  hold_when_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !cnt.clear && !(cnt.run && tick_i) |=> $stable(state.count))
    else $error("count moved while stopped");
endmodule
`default_nettype wire

// File: rtl/wdg_guard.sv
// guarded watchdog: mode and clear byte writes with illegal-access reset
// assumes the core presents one write per cycle with a bit-access flag;
// the slow oscillator is seen as a one-cycle tick on the system clock
//
// Summary of operation
// - mode byte takes whole-byte writes only; bit access is refused.
// - clear write with value other than ACH asserts internal reset.
// - bit access on the clear register asserts internal reset.
// - clear register always reads back 9AH.
// - unstoppable option keeps the counter running in stop standby.
// - unstoppable option resets on overflow during or after stop.
// - timer H1 clocks from slow oscillator; software clears watchdog.
// - stoppable option halts counting in halt or stop standby.
// - after standby the counter resumes with the saved clock selection.
// - standby entry and exit keep the count value.
// - mode accepts one write; a second one resets unless stopped.
// - stopped by first mode write: no violations cause reset.
`timescale 1ns/1ps
`default_nettype none
module wdg_guard
  import wdg_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic OPT_OSC_STOPPABLE_I,
  input wire logic SLOW_TICK_I,
  input wire logic HALT_I,
  input wire logic STOP_I,
  input wire logic MODE_WR_I,
  input wire logic CLEAR_WR_I,
  input wire logic BIT_ACCESS_I,
  input wire logic [7:0] WDATA_I,
  output logic [7:0] MODE_RDATA_O,
  output logic [7:0] CLEAR_RDATA_O,
  output logic RUNNING_O,
  output logic INT_RESET_O
);
  typedef struct packed {
    logic [7:0] wdog_mode_reg;
    logic mode_written;
    logic opt_taken;
    logic osc_stoppable;
    logic int_reset;
    logic clear_pend;
  } wdg_guard_state_t;

  wdg_guard_state_t state;
  wdg_guard_state_t next_state;
  wdg_cnt_if cnt_bus ();

  logic wdog_clock_select_hi;
  logic stopped;
  logic standby;
  logic violation;

  assign wdog_clock_select_hi = state.wdog_mode_reg[WDG_CS_HI_BIT];
  assign stopped = wdog_clock_select_hi;
  assign standby = HALT_I || STOP_I;

  // ==========================================================
  // write decoding
  // a byte write is any write that is not a 1-bit manipulation
  function automatic logic is_byte_write(input logic wr, input logic bit_acc);
    return wr && !bit_acc;
  endfunction

  function automatic logic is_clear_code(input logic [7:0] data);
    return data == WDG_CLEAR_CODE;
  endfunction

  // ==========================================================
  // access checking
  always_comb begin
    violation = 1'b0;
    if (!stopped) begin
      if (MODE_WR_I && (BIT_ACCESS_I || state.mode_written)) begin
        violation = 1'b1;
      end
      if (CLEAR_WR_I && BIT_ACCESS_I) begin
        violation = 1'b1;
      end
      if (is_byte_write(CLEAR_WR_I, BIT_ACCESS_I) && !is_clear_code(WDATA_I)) begin
        violation = 1'b1;
      end
    end
  end

  always_comb begin
    next_state = state;
    next_state.clear_pend = 1'b0;
    if (!state.opt_taken) begin
      next_state.opt_taken = 1'b1;
      next_state.osc_stoppable = OPT_OSC_STOPPABLE_I;
    end
    // bit access on the mode register is ignored, not stored
    if (is_byte_write(MODE_WR_I, BIT_ACCESS_I) && !state.mode_written) begin
      next_state.wdog_mode_reg = WDATA_I;
      next_state.mode_written = 1'b1;
    end
    if (is_byte_write(CLEAR_WR_I, BIT_ACCESS_I) && is_clear_code(WDATA_I)) begin
      // clears are honoured in standby too, so a timer interrupt can
      // service the watchdog while the core sleeps
      next_state.clear_pend = 1'b1;
    end
    // internal reset is sticky; only RST_I releases it
    if (violation || (cnt_bus.overflow && !stopped)) begin
      next_state.int_reset = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= '{wdog_mode_reg: WDG_MODE_RESET, default: '0};
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // counter control
  // standby does not touch clear or the saved rate, so the count and
  // clock selection survive a halt or stop
  assign cnt_bus.clear = state.clear_pend;
  assign cnt_bus.run = !stopped && state.opt_taken &&
    !(state.osc_stoppable && standby);
  assign cnt_bus.rate = state.wdog_mode_reg[2:0];

  wdg_counter #(
    .CNT_WIDTH(WDG_CNT_WIDTH)
  ) u_counter (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .tick_i(SLOW_TICK_I),
    .cnt(cnt_bus.counter)
  );

  assign MODE_RDATA_O = state.wdog_mode_reg;
  assign CLEAR_RDATA_O = WDG_CLEAR_READ;
  assign RUNNING_O = cnt_bus.run;
  assign INT_RESET_O = state.int_reset;

  // ==========================================================
  // checks
  sequence bad_clear_s;
    CLEAR_WR_I && !BIT_ACCESS_I && WDATA_I != WDG_CLEAR_CODE && !stopped;
  endsequence
  sequence bit_clear_s;
    CLEAR_WR_I && BIT_ACCESS_I && !stopped;
  endsequence

  bad_clear_reset_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    bad_clear_s |=> INT_RESET_O)
    else $error("wrong clear code did not reset");
  bit_clear_reset_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    bit_clear_s |=> INT_RESET_O)
    else $error("bit access to clear did not reset");
  clear_readback_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    CLEAR_RDATA_O == 8'h9a)
    else $error("clear readback wrong");
  second_mode_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    MODE_WR_I && state.mode_written && !stopped |=> INT_RESET_O)
    else $error("second mode write did not reset");
  stopped_quiet_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    stopped && !INT_RESET_O |=> !INT_RESET_O)
    else $error("reset while stopped");
  mode_bit_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    MODE_WR_I && BIT_ACCESS_I |=> $stable(MODE_RDATA_O))
    else $error("bit access changed mode");
  stop_runs_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    state.opt_taken && !state.osc_stoppable && !stopped && STOP_I |-> RUNNING_O)
    else $error("counter stopped in stop standby");
  standby_hold_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    state.osc_stoppable && standby |-> !RUNNING_O)
    else $error("counter ran in standby");
  overflow_reset_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    cnt_bus.overflow && !stopped |=> INT_RESET_O ##1 INT_RESET_O)
    else $error("overflow did not reset");
  option_fixed_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    state.opt_taken |=> $stable(state.osc_stoppable))
    else $error("option changed after reset");

  // ==========================================================
  // checks on the counter hand-over and the one-time mode write
  sequence good_clear_s;
    is_byte_write(CLEAR_WR_I, BIT_ACCESS_I) && is_clear_code(WDATA_I);
  endsequence
  sequence first_mode_s;
    is_byte_write(MODE_WR_I, BIT_ACCESS_I) && !state.mode_written;
  endsequence
  // the sampled reset keeps the release edge itself out of the latch check
  sequence option_open_s;
    !RST_I && !state.opt_taken;
  endsequence

  clear_restart_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    good_clear_s |=> ##1 (u_counter.state.count == '0))
    else $error("clear code did not restart the counter");
  mode_once_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    state.mode_written |=> $stable(MODE_RDATA_O))
    else $error("mode changed after the first write");
  first_mode_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    first_mode_s |=> MODE_RDATA_O == $past(WDATA_I))
    else $error("first mode byte not stored");
  rate_kept_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    state.mode_written |=> $stable(cnt_bus.rate))
    else $error("clock selection moved");
  option_latch_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    option_open_s |=> state.osc_stoppable == $past(OPT_OSC_STOPPABLE_I))
    else $error("start-up option not latched");
  reset_sticky_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    INT_RESET_O |=> INT_RESET_O)
    else $error("internal reset dropped");
  stop_overflow_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !state.osc_stoppable && STOP_I && cnt_bus.overflow && !stopped |=> INT_RESET_O)
    else $error("overflow in stop did not reset");
  run_needs_option_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !state.opt_taken |-> !RUNNING_O)
    else $error("counter ran before the option was latched");
endmodule
`default_nettype wire

// File: tb/wdg_core_model.sv
// core software model: byte and bit writes to the watchdog
// assumes the bench calls wr from its main thread
`timescale 1ns/1ps
`default_nettype none
module wdg_core_model
  import wdg_pkg::*;
(
  input wire logic clk_i,
  output logic mode_wr_o,
  output logic clear_wr_o,
  output logic bit_o,
  output logic [7:0] wdata_o
);
  // ======
  // write cycle
  initial begin
    mode_wr_o = 1'b0;
    clear_wr_o = 1'b0;
    bit_o = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic m, input logic [7:0] d, input logic b);
    @(posedge clk_i);
    mode_wr_o <= m;
    clear_wr_o <= !m;
    bit_o <= b;
    wdata_o <= m ? {WDG_MODE_TOP, d[4:0]} : d;
    @(posedge clk_i);
    mode_wr_o <= 1'b0;
    clear_wr_o <= 1'b0;
    // released lines show the inverse so stale data is never trusted
    bit_o <= !b;
    wdata_o <= ~wdata_o;
  endtask
endmodule
`default_nettype wire

// File: tb/watchdog_guard_access_tb.sv
// self-checking bench for the guarded watchdog
// assumes the core model drives the write port
`timescale 1ns/1ps
`default_nettype none
module watchdog_guard_access_tb
  import wdg_pkg::*;
;
  localparam logic [17:0] IR = 18'h00100;
  localparam logic [17:0] IRM = 18'h001ff;
  localparam logic [17:0] RN = 18'h00200;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic opt = 1'b0;
  logic tick = 1'b1;
  logic halt = 1'b0;
  logic stop = 1'b0;
  logic mwr, cwr, bacc, run, irst;
  logic [7:0] wd, mrd, crd, bad;
  logic [35:0] q[$];
  int errors = 0;
  int cmp_count = 0;
  int seed = 95984;
  event obs;
  always #12.5 clk = ~clk;
  wdg_core_model core_u (.clk_i(clk), .mode_wr_o(mwr), .clear_wr_o(cwr), .bit_o(bacc),
    .wdata_o(wd));
  wdg_guard dut_u (.CLK_I(clk), .RST_I(rst), .OPT_OSC_STOPPABLE_I(opt), .SLOW_TICK_I(tick),
    .HALT_I(halt), .STOP_I(stop), .MODE_WR_I(mwr), .CLEAR_WR_I(cwr), .BIT_ACCESS_I(bacc),
    .WDATA_I(wd), .MODE_RDATA_O(mrd), .CLEAR_RDATA_O(crd), .RUNNING_O(run),
    .INT_RESET_O(irst));
  // ======
  // helpers
  task automatic rst_dut(input logic o);
    @(posedge clk);
    rst <= 1'b1;
    opt <= o;
    stop <= 1'b0;
    halt <= 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic exp(input logic [17:0] m, input logic [17:0] v);
    @(negedge clk);
    q.push_back({m, v});
    ->obs;
  endtask
  always @(obs) begin
    logic [35:0] e;
    e = q.pop_front();
    cmp_count++;
    if (({crd, run, irst, mrd} & e[35:18]) !== (e[17:0] & e[35:18])) begin
      errors++;
      $display("Error %0t: got %h want %h", $time, {crd, run, irst, mrd}, e[17:0]);
    end
  end
  task automatic complete_run;
    $display("counts: %0d compares, %0d errors", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    complete_run();
  end
  // ======
  // scenarios
  initial begin
    rst_dut(1'b0);
    exp('1, 18'h26867);
    // software keeps the longest period for self-programming: it must outlast an erase
    cmp_count++;
    if ((64'd1 << (13 + 7)) < 64'(WDG_ERASE_MIN_CYC)) begin
      errors++;
      $display("Error %0t: longest period shorter than a block erase", $time);
    end
    core_u.wr(1'b1, 8'h60, 1'b1);
    exp(IRM, 18'h00167);
    rst_dut(1'b0);
    core_u.wr(1'b1, 8'h60, 1'b0);
    core_u.wr(1'b1, 8'h61, 1'b0);
    exp(IRM, 18'h00160);
    rst_dut(1'b0);
    core_u.wr(1'b0, 8'hac, 1'b1);
    exp(IR, 18'h00100);
    rst_dut(1'b0);
    core_u.wr(1'b1, 8'h70, 1'b0);
    core_u.wr(1'b1, 8'h61, 1'b0);
    core_u.wr(1'b0, 8'hac, 1'b1);
    core_u.wr(1'b0, 8'h13, 1'b0);
    exp(IRM, 18'h00070);
    $display("access tests done");
    rst_dut(1'b0);
    core_u.wr(1'b1, 8'h60, 1'b0);
    repeat (6000) @(posedge clk);
    core_u.wr(1'b0, 8'hac, 1'b0);
    repeat (6000) @(posedge clk);
    exp(IR, 18'h00000);
    bad = 8'($random(seed));
    if (bad == 8'hac) bad = 8'h5c;
    core_u.wr(1'b0, bad, 1'b0);
    exp(IR, 18'h00100);
    $display("clear test done");
    rst_dut(1'b0);
    core_u.wr(1'b1, 8'h60, 1'b0);
    // no slow-oscillator ticks: the count must stand still
    tick <= 1'b0;
    repeat (2000) @(posedge clk);
    tick <= 1'b1;
    repeat (7000) @(posedge clk);
    exp(IR, 18'h00000);
    repeat (1300) @(posedge clk);
    exp(IR, 18'h00100);
    $display("tick test done");
    rst_dut(1'b0);
    stop <= 1'b1;
    core_u.wr(1'b1, 8'h60, 1'b0);
    exp(RN, 18'h00200);
    repeat (6000) @(posedge clk);
    // the timer interrupt services the watchdog while the core is in stop
    core_u.wr(1'b0, 8'hac, 1'b0);
    repeat (6000) @(posedge clk);
    exp(IR, 18'h00000);
    repeat (2300) @(posedge clk);
    exp(IR, 18'h00100);
    rst_dut(1'b1);
    core_u.wr(1'b1, 8'h60, 1'b0);
    repeat (5000) @(posedge clk);
    // the option pin moves, the latched choice must not
    opt <= 1'b0;
    halt <= 1'b1;
    repeat (8300) @(posedge clk);
    exp(RN | IR, 18'h00000);
    @(posedge clk);
    halt <= 1'b0;
    repeat (3300) @(posedge clk);
    exp(IR, 18'h00100);
    $display("standby tests done");
    complete_run();
  end
endmodule
`default_nettype wire
